/* File: hw/address_space_decoder.sv */
// Purpose: Maps CPU fetches and data accesses onto memory, SFR and register file spaces.
// Assumes: One request per accepted cycle; answer registered one cycle later.
// Notes: ROM, configuration bytes, external memory and other SFRs are served outside.
`timescale 1ns/1ps

// Operation
// - Memory is one flat 16-Mbyte space of 256 regions, no segment registers.
// - On-chip RAM sits at address zero; its first 32 bytes hold four banks.
// - General data RAM starts right above the bank bytes.
// - Code ROM sits at the top region base; fetching starts there after reset.
// - Register file is its own space of 64 byte locations.
// - Register file locations 0 to 7 refer to the selected bank.
// - Two status-word bits pick the bank: 00 to 11 select bytes 00H-1FH.
// - Register file locations above the bank window never appear in memory.
// - A separate 512-entry SFR space, distinct from equal memory addresses.
// - Legacy code-space reads go into the top region.
// - Legacy external data uses the region byte and the low 16 bits unchanged.
// - The region byte resets to 01H.
// - Region byte is register file location 57 and SFR 084H, same storage.
// - Legacy 256-byte internal data maps onto the lowest region 00 bytes.
// - Region 00 is reachable by direct, indirect and displacement addressing.
// - Legacy SFR block sits at 080H onward with addresses unchanged.
// - Accumulator, B, pointer and stack bytes live in the register file and SFRs.
// - Only regions 00, 01, FE and FF are usable, 64 Kbytes each.
// - Instruction fetches are allowed from all four usable regions.
// - Reads of reserved regions return an unspecified value.
// - Writes to reserved regions are accepted and stored nowhere.
// - At most 18 external address lines, four regions of 64 Kbytes, 256 Kbytes in all.
// - Top eight bytes of region FF are configuration; two are implemented.
// - First 96 general RAM bytes are bit addressable; first 64 Kbytes direct.
// - General data RAM holds 512 or 1024 bytes.
// - Instructions are never fetched from on-chip data RAM.
module address_space_decoder
  import address_space_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic [1:0] bank_select,
  input wire logic req_valid,
  input wire access_t req,
  output logic resp_valid,
  output resp_t resp,
  output logic [23:0] reset_fetch_addr
);

  // Region number to the two upper external address lines
  function automatic logic [17:0] ext_map(input logic [23:0] a);
    logic [1:0] code;
    code = 2'b00;
    case (a[23:16])
      REGION_01: code = 2'b01;
      REGION_FE: code = 2'b10;
      REGION_FF: code = 2'b11;
      default: code = 2'b00;
    endcase
    ext_map = {code, a[15:0]};
  endfunction

  // Read-modify-write of one bit for bit-addressable bytes
  function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] idx,
                                           input logic val);
    logic [7:0] res;
    res = old;
    res[idx] = val;
    bit_merge = res;
  endfunction

  logic [7:0] onchip_q [0:ONCHIP_DEPTH-1];
  logic [7:0] rf_q [0:RF_LOCS-1];
  logic [7:0] region_sel_q;
  logic resp_valid_q;
  resp_t resp_q;

  logic accept;
  logic is_write;
  logic [23:0] eff;
  target_t tgt;
  logic err;
  logic [ONCHIP_IDX_W-1:0] ram_idx;
  logic [5:0] rf_idx;
  logic ram_we;
  logic rf_we;
  logic sel_we;
  logic use_sel;
  logic [7:0] wbyte;
  logic [7:0] rdata_d;

  assign accept = req_valid & clock_enable;
  assign reset_fetch_addr = RESET_FETCH_ADDR;

  // Effective linear address; legacy spaces fold in here
  always_comb begin
    case (req.kind)
      K_CODE_RD: eff = {REGION_FF, req.addr[15:0]};
      K_XDATA_RD, K_XDATA_WR: eff = {region_sel_q, req.addr[15:0]};
      K_IDATA_RD, K_IDATA_WR: eff = {16'h0000, req.addr[7:0]};
      default: eff = req.addr;
    endcase
  end

  assign is_write = (req.kind == K_MEM_WR) || (req.kind == K_XDATA_WR) ||
                    (req.kind == K_IDATA_WR);

  // Space decode: one target per access, write enables only for local storage
  always_comb begin
    tgt = T_NONE;
    err = 1'b0;
    ram_idx = '0;
    rf_idx = '0;
    ram_we = 1'b0;
    rf_we = 1'b0;
    sel_we = 1'b0;
    use_sel = 1'b0;
    case (req.kind)
      K_SFR_RD, K_SFR_WR: begin
        // SFR space is separate from memory; only core-held bytes answer here
        tgt = T_SFR_LOCAL;
        case (req.addr[8:0])
          SFR_ACC: rf_idx = RF_ACC;
          SFR_B: rf_idx = RF_B;
          SFR_DPL: rf_idx = RF_DPL;
          SFR_DPH: rf_idx = RF_DPH;
          SFR_SP: rf_idx = RF_SP;
          SFR_SPH: rf_idx = RF_SPH;
          SFR_REGION_SEL: use_sel = 1'b1;
          default: tgt = T_SFR_EXT;
        endcase
        if (req.addr[23:9] != '0) begin
          tgt = T_RESERVED;
          err = 1'b1;
        end
        if (req.kind == K_SFR_WR && tgt == T_SFR_LOCAL) begin
          sel_we = use_sel;
          rf_we = !use_sel;
        end
      end
      K_RF_RD, K_RF_WR: begin
        rf_idx = req.addr[5:0];
        if (req.addr[23:6] != '0 ||
            (rf_idx >= RF_RESV_LO && rf_idx <= RF_RESV_HI)) begin
          tgt = T_RESERVED;
          err = 1'b1;
        end else if (rf_idx[5:3] == 3'b000) begin
          // Bank window indexes the shared RAM bytes
          tgt = T_BANK;
          ram_idx = {6'b000000, bank_select, rf_idx[2:0]};
          ram_we = (req.kind == K_RF_WR);
        end else begin
          tgt = T_REGFILE;
          use_sel = (rf_idx == RF_REGION_SEL);
          sel_we = use_sel && (req.kind == K_RF_WR);
          rf_we = !use_sel && (req.kind == K_RF_WR);
        end
      end
      default: begin
        if (req.direct && eff[23:16] != REGION_00) begin
          // Direct addressing only reaches the first 64 Kbytes
          tgt = T_RESERVED;
          err = 1'b1;
        end else if (eff[23:16] == REGION_00) begin
          if (eff[15:0] < RAM_END && req.kind != K_FETCH) begin
            tgt = (eff[15:0] < BANK_BYTES) ? T_BANK : T_RAM;
            ram_idx = eff[ONCHIP_IDX_W-1:0];
            ram_we = is_write;
            if (req.bit_op && (eff[15:0] < RAM_BASE || eff[15:0] > BIT_AREA_LAST)) begin
              err = 1'b1;
              ram_we = 1'b0;
            end
          end else begin
            // Fetches in the RAM range go to the external bus instead
            tgt = T_EXTERNAL;
          end
        end else if (eff[23:16] == REGION_01 || eff[23:16] == REGION_FE) begin
          tgt = T_EXTERNAL;
        end else if (eff[23:16] == REGION_FF) begin
          if (eff[15:0] >= CONFIG_BASE) begin
            tgt = (eff[15:0] < CONFIG_USED_END) ? T_CONFIG : T_RESERVED;
            err = (req.kind == K_FETCH);
          end else if (eff[15:0] < ROM_BYTES && !is_write) begin
            tgt = T_ROM;
          end else begin
            tgt = T_EXTERNAL;
          end
        end else begin
          // Reserved regions: write dropped, read gives zero
          tgt = T_RESERVED;
        end
      end
    endcase
  end

  // Byte written into on-chip RAM, bit-merged when asked
  always_comb begin
    wbyte = req.wdata;
    if (req.bit_op) begin
      wbyte = bit_merge(onchip_q[ram_idx], req.bit_idx, req.wdata[0]);
    end
  end

  // Read data chosen at accept time
  always_comb begin
    rdata_d = 8'h00;
    if (use_sel) begin
      rdata_d = region_sel_q;
    end else if (tgt == T_BANK || tgt == T_RAM) begin
      rdata_d = onchip_q[ram_idx];
    end else if (tgt == T_REGFILE || tgt == T_SFR_LOCAL) begin
      rdata_d = rf_q[rf_idx];
    end
  end

  // On-chip RAM, banks included; one array keeps both views coherent
  always_ff @(posedge clock) begin
    if (accept && ram_we) begin
      onchip_q[ram_idx] <= wbyte;
    end
  end

  // Register file locations above the bank window
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < RF_LOCS; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else if (accept && rf_we) begin
      rf_q[rf_idx] <= req.wdata;
    end
  end

  // Region byte of the extended data pointer
  always_ff @(posedge clock) begin
    if (reset) begin
      region_sel_q <= REGION_SEL_RESET;
    end else if (accept && sel_we) begin
      region_sel_q <= req.wdata;
    end
  end

  // Registered answer, frozen while the clock enable is low
  always_ff @(posedge clock) begin
    if (reset) begin
      resp_valid_q <= 1'b0;
      resp_q <= '0;
    end else if (clock_enable) begin
      resp_valid_q <= req_valid;
      if (req_valid) begin
        resp_q.target <= tgt;
        resp_q.addr <= eff;
        resp_q.ext_addr <= ext_map(eff);
        resp_q.rdata <= rdata_d;
        resp_q.error <= err;
      end
    end
  end

  assign resp_valid = resp_valid_q;
  assign resp = resp_q;

  // Checks
  sequence sel_sfr_write_s;
    accept && req.kind == K_SFR_WR && req.addr == {15'h0000, SFR_REGION_SEL};
  endsequence

  sequence sel_rf_read_s;
    accept && req.kind == K_RF_RD && req.addr == {18'h00000, RF_REGION_SEL};
  endsequence

  // Answer timing
  answer_follows_a: assert property (@(posedge clock) disable iff (reset)
    accept |=> resp_valid)
    else $error("accepted request got no answer");

  answer_pulse_a: assert property (@(posedge clock) disable iff (reset)
    resp_valid && clock_enable && !req_valid |=> !resp_valid)
    else $error("answer stood longer than one cycle");

  // Nothing moves while frozen, so a stalled core sees a steady answer
  freeze_hold_a: assert property (@(posedge clock) disable iff (reset)
    !clock_enable && !reset
    |=> $stable(resp_valid) && $stable(resp) && $stable(region_sel_q))
    else $error("state moved while clock enable low");

  // Region byte: reset value, shared storage, legacy external data
  region_reset_a: assert property (@(posedge clock)
    reset |=> region_sel_q == REGION_SEL_RESET)
    else $error("region byte not 01 after reset");

  region_alias_a: assert property (@(posedge clock) disable iff (reset)
    sel_sfr_write_s ##1 sel_rf_read_s |=> resp.rdata == $past(req.wdata, 2))
    else $error("region byte views differ");

  xdata_map_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_XDATA_RD && region_sel_q == REGION_01
    |=> resp.target == T_EXTERNAL && resp.ext_addr == {2'b01, $past(req.addr[15:0])})
    else $error("legacy external data misplaced");

  // Reserved regions read as zero here; software must not rely on it
  reserved_read_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_XDATA_RD && region_sel_q > REGION_01 && region_sel_q < REGION_FE
    |=> resp.target == T_RESERVED && resp.rdata == 8'h00)
    else $error("reserved region read misdecoded");

  // Code space, legacy internal data and fetch targets
  code_top_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_CODE_RD |=> resp.addr[23:16] == REGION_FF)
    else $error("code read outside top region");

  idata_map_a: assert property (@(posedge clock) disable iff (reset)
    accept && (req.kind == K_IDATA_RD || req.kind == K_IDATA_WR)
    |=> resp.addr == {16'h0000, $past(req.addr[7:0])})
    else $error("legacy internal data misplaced");

  fetch_not_ram_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_FETCH |=> resp.target != T_RAM && resp.target != T_BANK)
    else $error("fetch served from data RAM");

  fetch_rom_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_FETCH && !req.direct && req.addr[23:16] == REGION_FF &&
    req.addr[15:0] < ROM_BYTES |=> resp.target == T_ROM)
    else $error("fetch from the top region missed the ROM");

  config_fetch_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_FETCH && req.addr[23:3] == 21'h1fffff |=> resp.error)
    else $error("fetch from configuration bytes not flagged");

  config_map_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_MEM_RD && req.addr == 24'hfffff9 |=> resp.target == T_CONFIG)
    else $error("configuration byte not decoded");

  // Refused accesses and the register file window
  reserved_drop_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_MEM_WR && req.addr[23:16] > REGION_01 &&
    req.addr[23:16] < REGION_FE |-> !ram_we && !rf_we ##1 resp.target == T_RESERVED)
    else $error("reserved region write stored");

  sfr_range_a: assert property (@(posedge clock) disable iff (reset)
    accept && (req.kind == K_SFR_RD || req.kind == K_SFR_WR) && req.addr[23:9] != '0
    |-> !sel_we && !rf_we ##1 resp.error && resp.target == T_RESERVED)
    else $error("SFR address above 1FF not refused");

  rf_reserved_a: assert property (@(posedge clock) disable iff (reset)
    accept && (req.kind == K_RF_RD || req.kind == K_RF_WR) &&
    req.addr[5:0] >= RF_RESV_LO && req.addr[5:0] <= RF_RESV_HI |=> resp.error)
    else $error("reserved register file location not refused");

  bank_window_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_RF_WR && req.addr[23:3] == '0
    |-> ram_we && ram_idx == {6'b000000, bank_select, req.addr[2:0]})
    else $error("bank window maps wrong byte");

  upper_rf_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_RF_WR && req.addr[23:6] == '0 && req.addr[5:3] != 3'b000
    |-> !ram_we)
    else $error("register file write reached memory");

  // Memory placement and external address lines
  bank_ram_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.kind == K_MEM_RD && req.addr < {8'h00, BANK_BYTES}
    |=> resp.target == T_BANK)
    else $error("bank bytes not at the bottom of memory");

  bit_area_a: assert property (@(posedge clock) disable iff (reset)
    accept && req.bit_op && req.kind == K_MEM_WR && req.addr[23:16] == REGION_00 &&
    (req.addr[15:0] < RAM_BASE || req.addr[15:0] > BIT_AREA_LAST) |-> !ram_we)
    else $error("bit write outside the bit area stored");

  ext_lines_a: assert property (@(posedge clock) disable iff (reset)
    resp_valid && resp.target == T_EXTERNAL && resp.addr[23:16] == REGION_FE
    |-> resp.ext_addr == {2'b10, resp.addr[15:0]})
    else $error("external address lines wrong for region FE");

endmodule

/* File: hw/address_space_pkg.sv */
// Purpose: Shared constants and types for the address-space decoder.
// Assumes: One CPU clock domain; byte-wide data on every access.
// Notes: Sizes are the larger on-chip variant (1 Kbyte RAM, 16 Kbyte ROM).
package address_space_pkg;

  // Memory space shape
  localparam int ADDR_W = 24;
  localparam int EXT_ADDR_W = 18;
  localparam logic [7:0] REGION_00 = 8'h00;
  localparam logic [7:0] REGION_01 = 8'h01;
  localparam logic [7:0] REGION_FE = 8'hfe;
  localparam logic [7:0] REGION_FF = 8'hff;
  localparam logic [23:0] RESET_FETCH_ADDR = 24'hff0000;

  // On-chip RAM: bank storage then general data RAM
  localparam logic [15:0] BANK_BYTES = 16'h0020;
  localparam logic [15:0] RAM_BASE = 16'h0020;
  localparam logic [15:0] RAM_BYTES = 16'h0400;
  localparam logic [15:0] RAM_END = 16'h0420;
  localparam int ONCHIP_DEPTH = 1056;
  localparam int ONCHIP_IDX_W = 11;
  localparam logic [15:0] BIT_AREA_LAST = 16'h007f;

  // On-chip ROM and configuration array in region FF
  localparam logic [15:0] ROM_BYTES = 16'h4000;
  localparam logic [15:0] CONFIG_BASE = 16'hfff8;
  localparam logic [15:0] CONFIG_USED_END = 16'hfffa;

  // Register file
  localparam int RF_LOCS = 64;
  localparam logic [5:0] RF_RESV_LO = 6'h20;
  localparam logic [5:0] RF_RESV_HI = 6'h37;
  localparam logic [5:0] RF_B = 6'h0a;
  localparam logic [5:0] RF_ACC = 6'h0b;
  localparam logic [5:0] RF_REGION_SEL = 6'h39;
  localparam logic [5:0] RF_DPH = 6'h3a;
  localparam logic [5:0] RF_DPL = 6'h3b;
  localparam logic [5:0] RF_SPH = 6'h3e;
  localparam logic [5:0] RF_SP = 6'h3f;
  localparam logic [7:0] REGION_SEL_RESET = 8'h01;

  // Special function register addresses served here
  localparam logic [8:0] SFR_SP = 9'h081;
  localparam logic [8:0] SFR_DPL = 9'h082;
  localparam logic [8:0] SFR_DPH = 9'h083;
  localparam logic [8:0] SFR_REGION_SEL = 9'h084;
  localparam logic [8:0] SFR_SPH = 9'h0be;
  localparam logic [8:0] SFR_ACC = 9'h0e0;
  localparam logic [8:0] SFR_B = 9'h0f0;

  typedef enum logic [3:0] {
    K_FETCH = 4'h0, K_MEM_RD = 4'h1, K_MEM_WR = 4'h2,
    K_SFR_RD = 4'h3, K_SFR_WR = 4'h4, K_RF_RD = 4'h5, K_RF_WR = 4'h6,
    K_CODE_RD = 4'h7, K_XDATA_RD = 4'h8, K_XDATA_WR = 4'h9,
    K_IDATA_RD = 4'ha, K_IDATA_WR = 4'hb
  } access_kind_t;

  typedef enum logic [3:0] {
    T_NONE = 4'h0, T_BANK = 4'h1, T_RAM = 4'h2, T_ROM = 4'h3,
    T_CONFIG = 4'h4, T_EXTERNAL = 4'h5, T_RESERVED = 4'h6,
    T_REGFILE = 4'h7, T_SFR_LOCAL = 4'h8, T_SFR_EXT = 4'h9
  } target_t;

  typedef struct packed {
    access_kind_t kind;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic direct;
    logic bit_op;
    logic [2:0] bit_idx;
  } access_t;

  typedef struct packed {
    target_t target;
    logic [23:0] addr;
    logic [17:0] ext_addr;
    logic [7:0] rdata;
    logic error;
  } resp_t;

endpackage

/* File: bench/cpu_model.sv */
// Purpose: CPU-side model issuing one decoder access at a time.
// Assumes: The answer is registered on the edge that takes the request.
// Notes: Released request fields show inverted values, never stale ones.
`timescale 1ns/1ps
module cpu_model
  import address_space_pkg::*;
(
  input wire logic clock,
  output logic req_valid,
  output access_t req,
  input wire logic resp_valid,
  input wire resp_t resp
);
  // Idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // Drive after an edge, hold to the taking edge, then collect the answer
  task automatic access(input access_t a, output resp_t r, output logic ok);
    @(posedge clock);
    req_valid <= 1'b1;
    req <= a;
    @(posedge clock);
    req_valid <= 1'b0;
    req <= access_t'(~a); // Stale fields would hide a missing capture
    ok = 1'b0;
    r = '0;
    for (int n = 0; n < 4 && !ok; n++) begin
      #1;
      ok = (resp_valid === 1'b1);
      if (ok) r = resp;
      else @(posedge clock);
    end
  endtask

  // Two requests on consecutive edges; each answer is taken after its own edge
  task automatic access_pair(input access_t a, input access_t b, output resp_t ra,
                             output resp_t rb, output logic ok);
    @(posedge clock);
    req_valid <= 1'b1;
    req <= a;
    @(posedge clock);
    req <= b;
    #1;
    ok = (resp_valid === 1'b1);
    ra = resp;
    @(posedge clock);
    req_valid <= 1'b0;
    req <= access_t'(~b);
    #1;
    ok = ok && (resp_valid === 1'b1);
    rb = resp;
  endtask
endmodule

/* File: bench/address_space_decoder_bench.sv */
// Purpose: Self-checking bench for the address-space decoder.
// Assumes: cpu_model issues one access at a time.
// Notes: Expected values come from the memory map, never from the design.
`timescale 1ns/1ps
module address_space_decoder_bench
  import address_space_pkg::*;
;
  logic clock, reset, clock_enable, req_valid, resp_valid, ok, dir, bop;
  logic [1:0] bank_select;
  logic [23:0] reset_fetch_addr;
  access_t req;
  resp_t resp, r, r2;
  logic [2:0] bidx;
  int num_errors, tests_run;
  logic [5:0] rf_loc [6];
  logic [8:0] sfr_loc [6];
  logic [7:0] resv [3];

  address_space_decoder address_space_decoder_i (.clock(clock), .reset(reset),
    .clock_enable(clock_enable), .bank_select(bank_select), .req_valid(req_valid),
    .req(req), .resp_valid(resp_valid), .resp(resp), .reset_fetch_addr(reset_fetch_addr));
  cpu_model cpu_model_i (.clock(clock), .req_valid(req_valid), .req(req),
    .resp_valid(resp_valid), .resp(resp));

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Compare helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_tgt(input target_t got, input target_t exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: target %h, expected %h", $time, got, exp);
    end
  endtask

  // One access; a missing answer counts as a mismatch
  task automatic go(input access_kind_t k, input logic [23:0] a, input logic [7:0] d);
    cpu_model_i.access('{k, a, d, dir, bop, bidx}, r, ok);
    chk(24'(ok), 24'h1);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    #(8 * 5000);
    num_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    clock_enable = 1'b1;
    bank_select = 2'h0;
    dir = 1'b0;
    bop = 1'b0;
    bidx = 3'h0;
    num_errors = 0;
    tests_run = 0;
    rf_loc = '{RF_ACC, RF_B, RF_DPL, RF_DPH, RF_SP, RF_SPH};
    sfr_loc = '{SFR_ACC, SFR_B, SFR_DPL, SFR_DPH, SFR_SP, SFR_SPH};
    resv = '{8'h02, 8'h80, 8'hfd};
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    chk(reset_fetch_addr, 24'hff0000);
    // Region byte: reset value, two views, legacy external data
    go(K_SFR_RD, 24'h000084, 8'h00);
    chk(24'(r.rdata), 24'h000001);
    go(K_SFR_WR, 24'h000084, 8'h5a);
    go(K_RF_RD, 24'h000039, 8'h00);
    chk(24'(r.rdata), 24'h00005a);
    go(K_RF_WR, 24'h000039, 8'h03);
    go(K_SFR_RD, 24'h000084, 8'h00);
    chk(24'(r.rdata), 24'h000003);
    go(K_XDATA_RD, 24'h001234, 8'h00);
    chk(r.addr, 24'h031234);
    chk_tgt(r.target, T_RESERVED);
    go(K_SFR_WR, 24'h000084, 8'h01);
    go(K_XDATA_RD, 24'h001234, 8'h00);
    chk(r.addr, 24'h011234);
    chk(24'(r.ext_addr), 24'h011234);
    // Reserved regions swallow writes quietly
    foreach (resv[i]) begin
      go(K_MEM_WR, {resv[i], 16'h0100}, 8'h77);
      chk_tgt(r.target, T_RESERVED);
      chk(24'(r.error), 24'h0);
    end
    // Every bank, both directions of the shared bytes
    for (int b = 0; b < 4; b++) begin
      @(posedge clock);
      bank_select <= 2'(b);
      go(K_RF_WR, 24'h000003, 8'(8'h40 + b));
      go(K_MEM_RD, 24'(8 * b + 3), 8'h00);
      chk_tgt(r.target, T_BANK);
      chk(24'(r.rdata), 24'(8'h40 + b));
      go(K_MEM_WR, 24'(8 * b + 5), 8'(8'h60 + b));
      go(K_RF_RD, 24'h000005, 8'h00);
      chk(24'(r.rdata), 24'(8'h60 + b));
    end
    // Upper register file stays out of memory
    go(K_MEM_WR, 24'h000008, 8'h12);
    go(K_RF_WR, 24'h000008, 8'h55);
    go(K_MEM_RD, 24'h000008, 8'h00);
    chk(24'(r.rdata), 24'h000012);
    // General RAM bounds and fetch targets
    go(K_MEM_WR, 24'h000020, 8'ha5);
    go(K_MEM_RD, 24'h000020, 8'h00);
    chk(24'(r.rdata), 24'h0000a5);
    go(K_MEM_RD, 24'h00041f, 8'h00);
    chk_tgt(r.target, T_RAM);
    go(K_MEM_RD, 24'h000420, 8'h00);
    chk_tgt(r.target, T_EXTERNAL);
    go(K_FETCH, 24'h000020, 8'h00);
    chk_tgt(r.target, T_EXTERNAL);
    go(K_FETCH, 24'hff0000, 8'h00);
    chk_tgt(r.target, T_ROM);
    go(K_FETCH, 24'hfe0000, 8'h00);
    chk_tgt(r.target, T_EXTERNAL);
    go(K_FETCH, 24'hfffff8, 8'h00);
    chk(24'(r.error), 24'h1);
    go(K_MEM_RD, 24'hfffff9, 8'h00);
    chk_tgt(r.target, T_CONFIG);
    go(K_CODE_RD, 24'h001234, 8'h00);
    chk(r.addr, 24'hff1234);
    go(K_IDATA_RD, 24'h0000ff, 8'h00);
    chk(r.addr, 24'h0000ff);
    // Direct and bit addressing limits
    dir = 1'b1;
    go(K_MEM_RD, 24'h0000ff, 8'h00);
    chk(24'(r.error), 24'h0);
    go(K_MEM_RD, 24'h010000, 8'h00);
    chk(24'(r.error), 24'h1);
    dir = 1'b0;
    bop = 1'b1;
    go(K_MEM_RD, 24'h00007f, 8'h00);
    chk(24'(r.error), 24'h0);
    go(K_MEM_RD, 24'h000080, 8'h00);
    chk(24'(r.error), 24'h1);
    // Bit writes merge into the byte inside the bit area only
    bidx = 3'h3;
    go(K_MEM_WR, 24'h000020, 8'h01);
    chk(24'(r.error), 24'h0);
    go(K_MEM_WR, 24'h000080, 8'h01);
    chk(24'(r.error), 24'h1);
    bidx = 3'h0;
    bop = 1'b0;
    go(K_MEM_RD, 24'h000020, 8'h00);
    chk(24'(r.rdata), 24'h0000ad);
    // Dedicated registers seen through their SFR addresses
    foreach (rf_loc[i]) begin
      go(K_RF_WR, 24'(rf_loc[i]), 8'(8'h30 + i));
      go(K_SFR_RD, 24'(sfr_loc[i]), 8'h00);
      chk(24'(r.rdata), 24'(8'h30 + i));
    end
    // SFR space apart from memory, register file bounds
    go(K_MEM_WR, 24'h000084, 8'hee);
    go(K_SFR_RD, 24'h000084, 8'h00);
    chk(24'(r.rdata), 24'h000001);
    go(K_SFR_RD, 24'h000200, 8'h00);
    chk(24'(r.error), 24'h1);
    go(K_SFR_RD, 24'h000080, 8'h00);
    chk_tgt(r.target, T_SFR_EXT);
    go(K_RF_RD, 24'h00003c, 8'h00);
    chk(24'(r.rdata), 24'h000000);
    go(K_RF_RD, 24'h000020, 8'h00);
    chk(24'(r.error), 24'h1);
    // Legacy writes and SFR writes of core-held bytes
    go(K_IDATA_WR, 24'h120090, 8'h3c);
    go(K_MEM_RD, 24'h000090, 8'h00);
    chk(24'(r.rdata), 24'h00003c);
    go(K_XDATA_WR, 24'h005678, 8'h11);
    chk(r.addr, 24'h015678);
    chk_tgt(r.target, T_EXTERNAL);
    go(K_SFR_WR, 24'h0000e0, 8'h9c);
    go(K_RF_RD, 24'h00000b, 8'h00);
    chk(24'(r.rdata), 24'h00009c);
    // Back-to-back SFR write then register file read of the region byte
    cpu_model_i.access_pair('{K_SFR_WR, 24'h000084, 8'hc3, 1'b0, 1'b0, 3'h0},
      '{K_RF_RD, 24'h000039, 8'h00, 1'b0, 1'b0, 3'h0}, r, r2, ok);
    chk(24'(ok), 24'h1);
    chk_tgt(r.target, T_SFR_LOCAL);
    chk(24'(r2.rdata), 24'h0000c3);
    // Clock enable low: the request is not taken and nothing changes
    @(posedge clock);
    clock_enable <= 1'b0;
    cpu_model_i.access('{K_SFR_WR, 24'h000084, 8'h77, 1'b0, 1'b0, 3'h0}, r, ok);
    chk(24'(ok), 24'h0);
    @(posedge clock);
    clock_enable <= 1'b1;
    go(K_SFR_RD, 24'h000084, 8'h00);
    chk(24'(r.rdata), 24'h0000c3);
    // Mid-run reset restores the region byte and clears the register file
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    go(K_SFR_RD, 24'h000084, 8'h00);
    chk(24'(r.rdata), 24'h000001);
    go(K_RF_RD, 24'h00000b, 8'h00);
    chk(24'(r.rdata), 24'h000000);
    finish_test();
  end
endmodule
